// ===== twc_ctrl.sv
// Purpose: multi-master two-wire bus controller with APB registers
// Assumes: open-drain pins resolved outside; ref_clk 50 MHz
// Notes:   one byte engine serves master and slave roles
`timescale 1ns/1ns
`default_nettype none
module twc_ctrl
    import twc_pkg::*;
#(
    parameter logic [15:0] HALF_DEFAULT = 16'(HALF_CYC)
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // open-drain bus pins
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe
);

    typedef struct packed {
        // configuration
        logic        enable;
        logic        msel;
        logic        txBit;
        logic        txak;
        logic [6:0]  ownAddr;
        logic [15:0] halfCnt;
        // status flags
        logic        byteDone;
        logic        addressed;
        logic        busy;
        logic        arbLost;
        logic        srw;
        logic        rxAck;
        // master clock generator
        twc_mst_type master_select;
        logic        lowPhase;
        logic [15:0] tmr;
        // byte engine
        logic        hold;
        logic [3:0]  bitCnt;
        logic        sawRise;
        logic        addrPhase;
        logic        slvActive;
        logic [7:0]  shift;
        logic [7:0]  txByte;
        logic [7:0]  rxData;
        // outputs
        logic        sclOe;
        logic        sdaOe;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } twc_state_type;

    twc_state_type s_q;
    twc_state_type s_d;
    twc_lines_type ln;

    // bus lines pass two flops before use
    twc_sync u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .lines   (ln)
    );

    // bit of the outgoing byte for the current bit slot, MSB first
    function automatic logic txBitOf(input logic [7:0] b,
                                     input logic [3:0] cnt);
        txBitOf = b[3'd7 - cnt[2:0]];
    endfunction : txBitOf

    // true when this end drives data bits of the current byte
    function automatic logic isSender(input twc_state_type st);
        isSender = st.txBit &&
            (st.master_select == M_RUN || (st.slvActive && !st.addrPhase));
    endfunction : isSender

    // register read data
    function automatic logic [31:0] readWord(input twc_state_type st,
                                             input logic [7:0] a);
        readWord = '0;
        unique case (a)
            OFS_BUS_CONTROL_REG: begin
                readWord[CTL_ENABLE_BIT] = st.enable;
                readWord[CTL_MSEL_BIT]   = st.msel;
                readWord[CTL_TX_BIT]     = st.txBit;
                readWord[CTL_TXAK_BIT]   = st.txak;
            end
            OFS_BUS_STATUS_REG: begin
                readWord[ST_DONE_BIT] = st.byteDone;
                readWord[ST_ADDR_BIT] = st.addressed;
                readWord[ST_BUSY_BIT] = st.busy;
                readWord[ST_ARB_BIT]  = st.arbLost;
                readWord[ST_SRW_BIT]  = st.srw;
                readWord[ST_RXAK_BIT] = st.rxAck;
            end
            OFS_BUS_DATA_IO:     readWord[7:0] = st.rxData;
            OFS_SLAVE_ADDR_REG:  readWord[7:SADDR_LSB] = st.ownAddr;
            OFS_HALF_PERIOD_REG: readWord[15:0] = st.halfCnt;
            default:             readWord = '0;
        endcase
    endfunction : readWord

    // bus condition and edge detection
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    assign sclRise   = ln.scl & ~ln.sclPrev;
    assign sclFall   = ~ln.scl & ln.sclPrev;
    assign startSeen = ln.scl & ln.sclPrev & ln.sdaPrev & ~ln.sda;
    assign stopSeen  = ln.scl & ln.sclPrev & ~ln.sdaPrev & ln.sda;

    // apb phases
    logic accessCyc;
    logic doneCyc;
    logic mapped;
    logic wrDone;
    logic rdDone;
    assign accessCyc = psel & penable & ~s_q.pready;
    assign doneCyc   = psel & penable & s_q.pready;
    assign mapped    = paddr == OFS_BUS_CONTROL_REG ||
                       paddr == OFS_BUS_STATUS_REG ||
                       paddr == OFS_BUS_DATA_IO ||
                       paddr == OFS_SLAVE_ADDR_REG ||
                       paddr == OFS_HALF_PERIOD_REG;
    assign wrDone    = doneCyc & pwrite;
    assign rdDone    = doneCyc & ~pwrite;

    // next state of the whole controller
    always_comb begin
        s_d         = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = '0;

        // apb: one wait state, answer registered
        if (accessCyc) begin
            s_d.pready  = 1'b1;
            s_d.prdata  = readWord(s_q, paddr);
            s_d.pslverr = ~mapped;
        end

        // software writes
        if (wrDone) begin
            unique case (paddr)
                OFS_BUS_CONTROL_REG: begin
                    s_d.enable    = pwdata[CTL_ENABLE_BIT];
                    s_d.msel      = pwdata[CTL_MSEL_BIT];
                    s_d.txBit     = pwdata[CTL_TX_BIT];
                    s_d.txak      = pwdata[CTL_TXAK_BIT];
                    s_d.addressed = 1'b0;
                    // select rising: start only on a free bus
                    if (pwdata[CTL_MSEL_BIT] && !s_q.msel) begin
                        if (s_q.busy || !pwdata[CTL_ENABLE_BIT]) begin
                            s_d.msel    = 1'b0;
                            s_d.arbLost = s_q.busy;
                        end else begin
                            s_d.master_select       = M_START;
                            s_d.tmr       = s_q.halfCnt;
                            s_d.slvActive = 1'b0;
                        end
                    end
                    // repeated start: only as holding master
                    if (pwdata[CTL_RSTA_BIT]) begin
                        if (s_q.master_select == M_RUN && s_q.hold) begin
                            s_d.master_select = M_RSTA1;
                            s_d.tmr = s_q.halfCnt;
                        end else begin
                            s_d.arbLost = 1'b1;
                        end
                    end
                end
                OFS_BUS_STATUS_REG: begin
                    if (pwdata[ST_ARB_BIT]) begin
                        s_d.arbLost = 1'b0;
                    end
                end
                OFS_BUS_DATA_IO: begin
                    if (s_q.txBit) begin
                        s_d.byteDone = 1'b0;
                        s_d.txByte   = pwdata[7:0];
                        if (s_q.hold) begin
                            s_d.hold = 1'b0;
                        end
                    end
                end
                OFS_SLAVE_ADDR_REG: begin
                    s_d.ownAddr = pwdata[7:SADDR_LSB];
                end
                OFS_HALF_PERIOD_REG: begin
                    s_d.halfCnt = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // data read in receive mode starts next byte
        if (rdDone && paddr == OFS_BUS_DATA_IO && !s_q.txBit) begin
            s_d.byteDone = 1'b0;
            if (s_q.hold) begin
                s_d.hold = 1'b0;
            end
        end

        // start and stop conditions seen on the bus
        if (startSeen) begin
            s_d.busy      = 1'b1;
            s_d.bitCnt    = '0;
            s_d.sawRise   = 1'b0;
            s_d.addrPhase = 1'b1;
            s_d.slvActive = 1'b0;
        end
        if (stopSeen) begin
            s_d.busy      = 1'b0;
            s_d.addrPhase = 1'b0;
            s_d.slvActive = 1'b0;
            if (s_q.master_select == M_OFF) begin
                s_d.hold = 1'b0;
            end else begin
                s_d.arbLost = 1'b1;
                s_d.master_select     = M_OFF;
                s_d.msel    = 1'b0;
                s_d.hold    = 1'b0;
            end
        end

        // rising scl: sample data or acknowledge
        if (sclRise) begin
            s_d.sawRise = 1'b1;
            if (s_q.bitCnt < ACK_BIT) begin
                s_d.shift = {s_q.shift[6:0], ln.sda};
                if (s_q.master_select == M_RUN && isSender(s_q) && !ln.sda &&
                    txBitOf(s_q.txByte, s_q.bitCnt)) begin
                    s_d.arbLost = 1'b1;
                    s_d.master_select     = M_OFF;
                    s_d.msel    = 1'b0;
                end
            end else begin
                s_d.rxAck = ln.sda;
                if (s_q.master_select == M_RUN && !s_q.txBit && !s_q.addrPhase &&
                    s_q.txak && !ln.sda) begin
                    s_d.arbLost = 1'b1;
                    s_d.master_select     = M_OFF;
                    s_d.msel    = 1'b0;
                end
            end
        end

        // falling scl: end of a bit slot
        if (sclFall && s_q.sawRise) begin
            s_d.sawRise = 1'b0;
            if (s_q.bitCnt == LAST_DATA_BIT) begin
                if (s_q.addrPhase && s_q.master_select == M_OFF &&
                    s_q.shift[7:1] == s_q.ownAddr) begin
                    s_d.slvActive = 1'b1;
                    s_d.addressed = 1'b1;
                    s_d.srw       = s_q.shift[0];
                end else if (s_q.addrPhase && s_q.master_select == M_OFF) begin
                    s_d.addrPhase = 1'b0;
                end
                if (!s_q.addrPhase && !s_q.txBit) begin
                    s_d.rxData = s_q.shift;
                end
            end
            if (s_q.bitCnt == ACK_BIT) begin
                s_d.bitCnt    = '0;
                s_d.addrPhase = 1'b0;
                if (s_q.master_select == M_RUN || s_q.slvActive) begin
                    s_d.byteDone = 1'b1;
                    s_d.hold     = 1'b1;
                end
                if (s_q.slvActive && !s_q.addrPhase && s_q.txBit &&
                    s_q.rxAck) begin
                    s_d.slvActive = 1'b0;
                    s_d.hold      = 1'b0;
                end
            end else begin
                s_d.bitCnt = s_q.bitCnt + 4'h1;
            end
        end

        // master sequencer and clock generator
        unique case (s_q.master_select)
            M_OFF: begin
                s_d.lowPhase = 1'b1;
            end
            M_START: begin
                if (s_q.tmr == '0) begin
                    s_d.master_select      = M_RUN;
                    s_d.hold     = 1'b1;
                    s_d.lowPhase = 1'b1;
                    s_d.tmr      = s_q.halfCnt;
                end else begin
                    s_d.tmr = s_q.tmr - 16'h1;
                end
            end
            M_RUN: begin
                if (s_q.hold) begin
                    // after a byte: stop, repeat or wait
                    s_d.lowPhase = 1'b1;
                    if (s_d.master_select == M_RUN) begin
                        s_d.tmr = s_q.halfCnt;
                    end
                    if (!s_q.msel) begin
                        s_d.master_select = M_STOP1;
                    end
                end else if (s_q.lowPhase) begin
                    if (s_q.tmr == '0) begin
                        s_d.lowPhase = 1'b0;
                        s_d.tmr      = s_q.halfCnt;
                    end else begin
                        s_d.tmr = s_q.tmr - 16'h1;
                    end
                end else if (sclFall) begin
                    s_d.lowPhase = 1'b1;
                    s_d.tmr      = s_q.halfCnt;
                end else if (ln.scl) begin
                    if (s_q.tmr == '0) begin
                        s_d.lowPhase = 1'b1;
                        s_d.tmr      = s_q.halfCnt;
                    end else begin
                        s_d.tmr = s_q.tmr - 16'h1;
                    end
                end
            end
            M_RSTA1, M_STOP1: begin
                if (s_q.tmr == '0) begin
                    s_d.master_select = (s_q.master_select == M_RSTA1) ? M_RSTA2 : M_STOP2;
                    s_d.tmr = s_q.halfCnt;
                    s_d.hold = 1'b0;
                end else begin
                    s_d.tmr = s_q.tmr - 16'h1;
                end
            end
            M_RSTA2, M_STOP2: begin
                if (ln.scl) begin
                    if (s_q.tmr == '0) begin
                        s_d.master_select  = (s_q.master_select == M_RSTA2) ? M_START : M_OFF;
                        s_d.tmr  = s_q.halfCnt;
                        s_d.hold = 1'b0;
                    end else begin
                        s_d.tmr = s_q.tmr - 16'h1;
                    end
                end
            end
            default: begin
                s_d.master_select = M_OFF;
            end
        endcase

        // disabled controller leaves the bus alone
        if (!s_d.enable) begin
            s_d.master_select       = M_OFF;
            s_d.msel      = 1'b0;
            s_d.hold      = 1'b0;
            s_d.slvActive = 1'b0;
            s_d.addrPhase = 1'b0;
        end

        // open-drain drive: only pull low or release
        s_d.sclOe = s_d.hold || s_d.master_select == M_RSTA1 ||
                    s_d.master_select == M_STOP1 ||
                    (s_d.master_select == M_RUN && s_d.lowPhase);
        s_d.sdaOe = s_d.master_select == M_START || s_d.master_select == M_STOP1 ||
                    (s_q.master_select == M_START && s_d.master_select == M_RUN) ||
                    s_d.master_select == M_STOP2 ||
                    (isSender(s_d) && s_d.bitCnt < ACK_BIT &&
                     !txBitOf(s_d.txByte, s_d.bitCnt)) ||
                    (s_d.bitCnt == ACK_BIT && s_d.addrPhase &&
                     s_d.slvActive) ||
                    (s_d.bitCnt == ACK_BIT && !s_d.addrPhase &&
                     !s_d.txBit && !s_d.txak &&
                     (s_d.master_select == M_RUN || s_d.slvActive));
    end

    // state register; reset leaves the block disabled
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q          <= '0;
            s_q.halfCnt  <= HALF_DEFAULT;
            s_q.ownAddr  <= SADDR_RESET;
            s_q.lowPhase <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register; sclOut and sdaOut tied low
    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign sclOe   = s_q.sclOe;
    assign sdaOe   = s_q.sdaOe;
    assign sclOut  = 1'b0;
    assign sdaOut  = 1'b0;

endmodule : twc_ctrl
`default_nettype wire

// ===== twc_pkg.sv
// Purpose: shared constants and types of the two-wire bus controller
// Assumes: 50 MHz reference clock, APB register access, 32-bit data
// Notes:   byte addresses of the register words, bit positions, timing
package twc_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_BUS_CONTROL_REG = 8'h00;
    localparam logic [7:0] OFS_BUS_STATUS_REG  = 8'h04;
    localparam logic [7:0] OFS_BUS_DATA_IO     = 8'h08;
    localparam logic [7:0] OFS_SLAVE_ADDR_REG  = 8'h0c;
    localparam logic [7:0] OFS_HALF_PERIOD_REG = 8'h10;

    // control register fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_MSEL_BIT   = 5;
    localparam int CTL_TX_BIT     = 4;
    localparam int CTL_TXAK_BIT   = 3;
    localparam int CTL_RSTA_BIT   = 2;

    // status register fields
    localparam int ST_DONE_BIT = 7;
    localparam int ST_ADDR_BIT = 6;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_ARB_BIT  = 4;
    localparam int ST_SRW_BIT  = 2;
    localparam int ST_RXAK_BIT = 0;

    // slave address field sits in bits 7..1
    localparam int SADDR_LSB = 1;

    // timing: half an SCL period at the default bit rate
    localparam int CLK_PERIOD_NS  = 20;
    localparam int HALF_PERIOD_NS = 5000;
    localparam int HALF_CYC       =
        (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT       = 4'h8;
    localparam logic [6:0] SADDR_RESET   = 7'h00;

    // master sequencer states
    typedef enum logic [2:0] {
        M_OFF   = 3'b000,
        M_START = 3'b001,
        M_RUN   = 3'b010,
        M_RSTA1 = 3'b011,
        M_RSTA2 = 3'b100,
        M_STOP1 = 3'b101,
        M_STOP2 = 3'b110
    } twc_mst_type;

    // synchronised bus lines with their previous samples
    typedef struct packed {
        logic scl;
        logic sda;
        logic sclPrev;
        logic sdaPrev;
    } twc_lines_type;

endpackage : twc_pkg

// ===== twc_sync.sv
// Purpose: two-flop synchroniser for SCL and SDA plus one history stage
// Assumes: pins are asynchronous to ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module twc_sync
    import twc_pkg::*;
(
    // clock and reset
    input  wire logic    ref_clk,
    input  wire logic    rstn,
    // raw bus levels
    input  wire logic    sclIn,
    input  wire logic    sdaIn,
    // synchronised levels
    output var twc_lines_type lines
);

    typedef struct packed {
        logic [1:0]    meta;
        twc_lines_type ln;
    } twc_sync_type;

    twc_sync_type s_q;
    twc_sync_type s_d;

    // second stage and history; bus idles high
    always_comb begin
        s_d            = s_q;
        s_d.meta       = {sclIn, sdaIn};
        s_d.ln.sclPrev = s_q.ln.scl;
        s_d.ln.sdaPrev = s_q.ln.sda;
        s_d.ln.scl     = s_q.meta[1];
        s_d.ln.sda     = s_q.meta[0];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign lines = s_q.ln;

endmodule : twc_sync
`default_nettype wire

// ===== twc_assertions.sv
// Purpose: port checks of the two-wire bus controller
// Assumes: bus lines are pulled up outside the block
// Notes:   bound into every twc_ctrl instance
`timescale 1ns/1ns
`default_nettype none
module twc_assertions
    import twc_pkg::*;
(
    // clock, reset, apb answer and bus pins
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclIn,
    input wire logic        sclOe,
    input wire logic        sdaIn,
    input wire logic        sdaOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // apb answer comes after one wait state and stands one cycle
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stuck");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("stray error");
    // bus pins: quiet after reset, start on free bus, clock sync
    reset_quiet_a: assert property ($rose(rstn) |-> (!sclOe && !sdaOe)[*3])
        else $error("pins pulled after reset");
    start_free_a: assert property ($rose(sdaOe) && sclIn |-> $past(sdaIn))
        else $error("start on busy bus");
    scl_sync_a: assert property ($rose(sclOe) |-> $past(sclIn, 2))
        else $error("clock pulled while low");
    sda_setup_a: assert property ($fell(sclOe) |-> $stable(sdaOe))
        else $error("data moved with clock");
endmodule : twc_assertions
bind twc_ctrl twc_assertions u_chk (.ref_clk(ref_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclIn), .sclOe(sclOe), .sdaIn(sdaIn),
    .sdaOe(sdaOe));
`default_nettype wire

// ===== twc_slave_model.sv
// Purpose: behavioural target device on the two-wire bus
// Assumes: levels resolved with pull-ups by the bench
// Notes:   follows one call per start; stretches after each ack
`timescale 1ns/1ns
`default_nettype none
module twc_slave_model #(
    parameter logic [6:0] ADDR = 7'h5a,
    parameter logic [7:0] TXB  = 8'h3c,
    parameter int         STR  = 400
)(
    // resolved bus levels
    input  wire logic  sclW,
    input  wire logic  sdaW,
    // pulls and what was seen
    output var logic       sclPull = 1'b0,
    output var logic       sdaPull = 1'b0,
    output var logic [7:0] lastRx = 8'h00,
    output var logic [7:0] nStop = 8'h00
);
    logic [7:0] b;
    logic       nk;
    // take eight bits, msb first, while clock is high
    task automatic rx_byte();
        for (int i = 7; i >= 0; i--) begin
            @(posedge sclW);
            b[i] = sdaW;
            @(negedge sclW);
        end
    endtask : rx_byte
    // ninth clock answer, then hold the clock low
    task automatic ack(logic a);
        #60 sdaPull = a;
        @(posedge sclW);
        @(negedge sclW);
        sclPull = 1'b1;
        #60 sdaPull = 1'b0;
    endtask : ack
    // shift a byte out, stretching the first low phase
    task automatic tx_byte();
        for (int i = 7; i >= 0; i--) begin
            sdaPull = !TXB[i];
            if (i == 7) #STR sclPull = 1'b0;
            @(posedge sclW);
            @(negedge sclW);
            #60;
        end
        sdaPull = 1'b0;
        @(posedge sclW);
        nk = sdaW;
        @(negedge sclW);
    endtask : tx_byte
    // one call: address byte, then bytes the called way
    always @(negedge sdaW) begin : body
        if (sclW) begin
            rx_byte();
            nk = (b[7:1] != ADDR);
            ack(!nk);
            if (b[0] && !nk) begin
                while (!nk) tx_byte();
            end else begin
                #STR sclPull = 1'b0;
                while (!nk) begin
                    rx_byte();
                    lastRx = b;
                    ack(1'b1);
                    #STR sclPull = 1'b0;
                end
            end
        end
    end
    // stop ends the call and frees both lines
    always @(posedge sdaW) begin
        if (sclW) begin
            disable body;
            sclPull = 1'b0;
            sdaPull = 1'b0;
            nStop = nStop + 8'h01;
        end
    end
endmodule : twc_slave_model
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench of the two-wire bus controller
// Assumes: one target on the bus, pull-ups on both lines
// Notes:   half period register set to 4, so each half lasts at least 5 clocks, a bit time of 200 ns or more
`timescale 1ns/1ns
`default_nettype none
module tb
    import twc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, sclOe, sdaOe, sPull, dPull;
    logic [7:0] lastRx, nStop;
    wire logic sclW = !(sclOe || sPull);
    wire logic sdaW = !(sdaOe || dPull);
    int n_errors = 0;
    int cmp_count = 0;
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    twc_ctrl DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclW),
        .sclOut(), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(), .sdaOe(sdaOe));
    twc_slave_model u_tgt (.sclW(sclW), .sdaW(sdaW), .sclPull(sPull),
        .sdaPull(dPull), .lastRx(lastRx), .nStop(nStop));
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one apb transfer, held until ready is sampled
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_st(int pos, logic val);
        for (int i = 0; i < 300; i++) begin
            apb(1'b0, OFS_BUS_STATUS_REG, 32'h0);
            if (rd[pos] === val) return;
        end
        chk("status wait", 32'(rd[pos]), 32'(val));
    endtask : wait_st
    task automatic call(logic [7:0] a);
        apb(1'b1, OFS_BUS_CONTROL_REG, 32'hb0);
        wait_st(ST_BUSY_BIT, 1'b1);
        apb(1'b1, OFS_BUS_DATA_IO, 32'(a));
        wait_st(ST_DONE_BIT, 1'b1);
    endtask : call
    task automatic stop_call();
        logic [7:0] n0;
        n0 = nStop;
        apb(1'b1, OFS_BUS_CONTROL_REG, 32'h80);
        wait_st(ST_BUSY_BIT, 1'b0);
        chk("stop", 32'(nStop), 32'(n0 + 8'h01));
        chk("arb", 32'(rd[ST_ARB_BIT]), 32'h0);
    endtask : stop_call
    task automatic t_reset();
        chk("pins", 32'({sclOe, sdaOe}), 32'h0);
        apb(1'b0, OFS_BUS_CONTROL_REG, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        apb(1'b1, OFS_BUS_CONTROL_REG, 32'h84);
        apb(1'b0, OFS_BUS_STATUS_REG, 32'h0);
        chk("arb set", 32'(rd[ST_ARB_BIT]), 32'h1);
        apb(1'b1, OFS_BUS_STATUS_REG, 32'h10);
        apb(1'b0, OFS_BUS_STATUS_REG, 32'h0);
        chk("arb clr", 32'(rd[ST_ARB_BIT]), 32'h0);
    endtask : t_reset
    task automatic t_write();
        apb(1'b1, OFS_HALF_PERIOD_REG, 32'h4);
        call(8'hb4);
        chk("ack", 32'(rd[ST_RXAK_BIT]), 32'h0);
        apb(1'b0, OFS_BUS_DATA_IO, 32'h0);
        chk("readback", rd, 32'h0);
        apb(1'b1, OFS_BUS_DATA_IO, 32'ha5);
        apb(1'b0, OFS_BUS_STATUS_REG, 32'h0);
        chk("done clr", 32'(rd[ST_DONE_BIT]), 32'h0);
        wait_st(ST_DONE_BIT, 1'b1);
        chk("byte out", 32'(lastRx), 32'ha5);
        stop_call();
    endtask : t_write
    task automatic t_nack();
        call(8'h44);
        chk("nack", 32'(rd[ST_RXAK_BIT]), 32'h1);
        apb(1'b1, OFS_BUS_CONTROL_REG, 32'hb4);
        repeat (100) @(posedge ref_clk);
        apb(1'b1, OFS_BUS_DATA_IO, 32'hb4);
        wait_st(ST_DONE_BIT, 1'b1);
        chk("rsta ack", 32'(rd[ST_RXAK_BIT]), 32'h0);
        stop_call();
    endtask : t_nack
    task automatic t_read();
        call(8'hb5);
        chk("rd ack", 32'(rd[ST_RXAK_BIT]), 32'h0);
        apb(1'b1, OFS_BUS_CONTROL_REG, 32'ha8);
        apb(1'b0, OFS_BUS_DATA_IO, 32'h0);
        wait_st(ST_DONE_BIT, 1'b1);
        apb(1'b1, OFS_BUS_CONTROL_REG, 32'hb8);
        apb(1'b0, OFS_BUS_DATA_IO, 32'h0);
        chk("byte in", rd, 32'h3c);
        stop_call();
    endtask : t_read
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_write();
        t_nack();
        t_read();
        report_and_stop();
    end
    // a hang counts as a mismatch
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
